// >>> core/psp_fifo.sv
// Purpose: small shift-register fifo for outgoing bytes
// Assumes: synchronous active-high reset
// Notes:   head word and both flags come straight from flops
`timescale 1ns/100ps
module psp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic   i_sys_clk,
    input  wire logic   i_reset,
    // filling side
    psp_stream_if.snk   wr,
    // draining side
    psp_stream_if.src   rd
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          push;
    logic          pop;
    logic          rdy_reg;
    logic          vld_reg;

    assign push     = wr.valid && rdy_reg;
    assign pop      = rd.ready && vld_reg;
    assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
    assign wr.ready = rdy_reg;
    assign rd.valid = vld_reg;
    assign rd.data  = mem_reg[0];

    // occupancy and registered flags, so ready truly drops when full
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cnt_reg <= '0;
            rdy_reg <= 1'b1;
            vld_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            rdy_reg <= (cnt_next != CW'(DEPTH));
            vld_reg <= (cnt_next != '0);
        end
    end

    // storage shifts toward the head on each pop
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && (CW'(i) == (pop ? cnt_reg - CW'(1) : cnt_reg))) begin
                mem_reg[i] <= wr.data;
            end else if (pop && i < DEPTH - 1) begin
                mem_reg[i] <= mem_reg[i+1];
            end
        end
    end
endmodule : psp_fifo

// >>> core/psp_pkg.sv
// Purpose: types shared by the program serial port modules
// Assumes: constants live in psp_regs.svh
// Notes:   enums only
package psp_pkg;
    typedef enum logic [2:0] {
        PSP_R300   = 3'h0,
        PSP_R600   = 3'h1,
        PSP_R1200  = 3'h2,
        PSP_R2400  = 3'h3,
        PSP_R4800  = 3'h4,
        PSP_R9600  = 3'h5,
        PSP_R19200 = 3'h6
    } psp_rate_t;

    typedef enum logic [1:0] {
        PSP_RX_IDLE  = 2'h0,
        PSP_RX_START = 2'h1,
        PSP_RX_DATA  = 2'h2,
        PSP_RX_STOP  = 2'h3
    } psp_rx_state_t;

    typedef enum logic [1:0] {
        PSP_TX_IDLE  = 2'h0,
        PSP_TX_START = 2'h1,
        PSP_TX_DATA  = 2'h2,
        PSP_TX_STOP  = 2'h3
    } psp_tx_state_t;
endpackage : psp_pkg

// >>> core/psp_program_port.sv
// Purpose: program serial port, fixed 8N1 uart with wrap and xon/xoff
// Assumes: 25 MHz clock, synchronous active-high reset
// Notes:   rate, column clear and output activity come from the interpreter
//
// Contract
// - reset selects 1200 baud
// - rate command picks 300 to 19200 baud
// - frame is one start, eight data, one stop
// - received bytes have top bit cleared
// - output keeps eight bits, xoff code dropped
// - auto cr lf after column 79
// - column clear command zeroes column counter
// - xoff during output suspends immediately
// - xoff otherwise suspends at next output
// - xon resumes execution and output
// - input upper-cased outside quoted strings
// - mark is one, space is zero
`timescale 1ns/100ps
`include "psp_regs.svh"
module psp_program_port
    import psp_pkg::*;
#(
    parameter int CLK_HZ = 25000000,
    parameter int DEPTH  = 4
) (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    // serial line
    input  wire logic       i_rxd,
    output logic            o_txd,
    // interpreter commands
    input  wire logic [2:0] i_rate_sel,
    input  wire logic       i_rate_load,
    input  wire logic       i_col_clear,
    input  wire logic       i_output_active,
    output logic            o_suspend,
    // outgoing bytes
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_valid,
    output logic            o_tx_ready,
    // incoming bytes
    output logic [7:0]      o_rx_data,
    output logic            o_rx_valid
);
    // bit period in clocks for a rate code
    function automatic logic [19:0] rate_div(input logic [2:0] sel);
        logic [31:0] baud;
        baud = `PSP_BAUD_1200;
        case (sel)
            PSP_R300:   baud = `PSP_BAUD_300;
            PSP_R600:   baud = `PSP_BAUD_600;
            PSP_R1200:  baud = `PSP_BAUD_1200;
            PSP_R2400:  baud = `PSP_BAUD_2400;
            PSP_R4800:  baud = `PSP_BAUD_4800;
            PSP_R9600:  baud = `PSP_BAUD_9600;
            PSP_R19200: baud = `PSP_BAUD_19200;
            default:    baud = `PSP_BAUD_1200;
        endcase
        return 20'(CLK_HZ / baud);
    endfunction : rate_div

    psp_stream_if #(.W(8)) in_s ();
    psp_stream_if #(.W(8)) out_s ();

    logic [19:0]   div_reg;
    logic          rx_meta_reg;
    logic          rx_sync_reg;
    psp_rx_state_t rx_st;
    logic [19:0]   rx_cnt_reg;
    logic [3:0]    rx_bit_reg;
    logic [7:0]    rx_sh_reg;
    logic          quote_reg;
    logic          rx_done;
    logic [7:0]    rx_byte;
    logic          rx_xoff;
    logic          rx_xon;
    logic          pend_reg;
    psp_tx_state_t tx_st;
    logic [19:0]   tx_cnt_reg;
    logic [3:0]    tx_bit_reg;
    logic [7:0]    tx_sh_reg;
    logic [6:0]    col_reg;
    logic [1:0]    ins_reg;
    logic          tx_load;
    logic          tx_fifo;
    logic [7:0]    tx_byte;

    // outgoing bytes pass the fifo; back-pressure reaches the interpreter
    assign in_s.data   = i_tx_data;
    assign in_s.valid  = i_tx_valid;
    assign o_tx_ready  = in_s.ready;

    psp_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .wr        (in_s),
        .rd        (out_s)
    );

    // bit rate, reloaded only by the rate command
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            div_reg <= rate_div(`PSP_RESET_RATE);
        end else if (i_rate_load) begin
            div_reg <= rate_div(i_rate_sel);
        end
    end

    // line synchroniser, mark reads as one
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= i_rxd;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // receiver samples mid-bit; a bad stop bit drops the byte
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rx_st      <= PSP_RX_IDLE;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_sh_reg  <= '0;
        end else begin
            rx_cnt_reg <= (rx_cnt_reg == '0) ? div_reg - 20'h1 : rx_cnt_reg - 20'h1;
            case (rx_st)
                PSP_RX_IDLE: begin
                    rx_cnt_reg <= div_reg >> 1;
                    if (!rx_sync_reg) rx_st <= PSP_RX_START;
                end
                PSP_RX_START: begin
                    rx_bit_reg <= '0;
                    if (rx_cnt_reg == '0) begin
                        rx_st <= rx_sync_reg ? PSP_RX_IDLE : PSP_RX_DATA;
                    end
                end
                PSP_RX_DATA: begin
                    if (rx_cnt_reg == '0) begin
                        rx_sh_reg  <= {rx_sync_reg, rx_sh_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == `PSP_DATA_BITS - 4'h1) rx_st <= PSP_RX_STOP;
                    end
                end
                PSP_RX_STOP: begin
                    if (rx_cnt_reg == '0) rx_st <= PSP_RX_IDLE;
                end
                default: rx_st <= PSP_RX_IDLE;
            endcase
        end
    end

    assign rx_done = (rx_st == PSP_RX_STOP) && (rx_cnt_reg == '0) && rx_sync_reg;
    assign rx_byte = rx_sh_reg & `PSP_RX_MASK;
    assign rx_xoff = rx_done && (rx_byte == `PSP_XOFF);
    assign rx_xon  = rx_done && (rx_byte == `PSP_XON);

    // delivery with case folding outside quotes; flow codes are consumed
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rx_data  <= '0;
            o_rx_valid <= 1'b0;
            quote_reg  <= 1'b0;
        end else begin
            o_rx_valid <= rx_done && !rx_xoff && !rx_xon;
            if (rx_done) begin
                if (rx_byte == `PSP_QUOTE) quote_reg <= !quote_reg;
                else if (rx_byte == `PSP_CR) quote_reg <= 1'b0;
                if (!quote_reg && rx_byte >= `PSP_LOWER_A && rx_byte <= `PSP_LOWER_Z) begin
                    o_rx_data <= rx_byte & ~`PSP_CASE_BIT;
                end else begin
                    o_rx_data <= rx_byte;
                end
            end
        end
    end

    // xoff waits for an output statement, xon always releases
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pend_reg  <= 1'b0;
            o_suspend <= 1'b0;
        end else if (rx_xon) begin
            pend_reg  <= 1'b0;
            o_suspend <= 1'b0;
        end else begin
            if (rx_xoff) pend_reg <= 1'b1;
            if ((rx_xoff || pend_reg) && i_output_active) begin
                o_suspend <= 1'b1;
            end
        end
    end

    // next byte: inserted cr/lf first, then fifo; frames never cut short
    assign tx_fifo = (ins_reg == 2'h0) && out_s.valid;
    assign tx_load = (tx_st == PSP_TX_IDLE) && !o_suspend
                     && (ins_reg != 2'h0 || (out_s.valid && out_s.data != `PSP_XOFF));
    assign tx_byte = (ins_reg == 2'h2) ? `PSP_CR : (ins_reg == 2'h1) ? `PSP_LF : out_s.data;
    assign out_s.ready = (tx_st == PSP_TX_IDLE) && !o_suspend && tx_fifo;

    // transmitter shifts lsb first, line idles at mark
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            tx_st      <= PSP_TX_IDLE;
            tx_cnt_reg <= '0;
            tx_bit_reg <= '0;
            tx_sh_reg  <= '0;
            o_txd      <= 1'b1;
        end else begin
            tx_cnt_reg <= (tx_cnt_reg == '0) ? div_reg - 20'h1 : tx_cnt_reg - 20'h1;
            case (tx_st)
                PSP_TX_IDLE: begin
                    o_txd <= 1'b1;
                    if (tx_load) begin
                        tx_sh_reg  <= tx_byte;
                        tx_cnt_reg <= div_reg - 20'h1;
                        tx_st      <= PSP_TX_START;
                        o_txd      <= 1'b0;
                    end
                end
                PSP_TX_START: begin
                    tx_bit_reg <= '0;
                    if (tx_cnt_reg == '0) begin
                        tx_st <= PSP_TX_DATA;
                        o_txd <= tx_sh_reg[0];
                    end
                end
                PSP_TX_DATA: begin
                    if (tx_cnt_reg == '0) begin
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg == `PSP_DATA_BITS - 4'h1) begin
                            tx_st <= PSP_TX_STOP;
                            o_txd <= 1'b1;
                        end else begin
                            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                            o_txd     <= tx_sh_reg[1];
                        end
                    end
                end
                PSP_TX_STOP: begin
                    if (tx_cnt_reg == '0) tx_st <= PSP_TX_IDLE;
                end
                default: tx_st <= PSP_TX_IDLE;
            endcase
        end
    end

    // column tracking and wrap insertion; clear command has the last word
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            col_reg <= '0;
            ins_reg <= 2'h0;
        end else begin
            if (tx_load && !tx_fifo) begin
                ins_reg <= ins_reg - 2'h1;
                if (ins_reg == 2'h2) col_reg <= '0;
            end else if (tx_load) begin
                if (tx_byte == `PSP_CR) begin
                    col_reg <= '0;
                end else if (tx_byte >= `PSP_SPACE) begin
                    col_reg <= col_reg + 7'h1;
                    if (col_reg + 7'h1 == `PSP_WRAP_COL) ins_reg <= 2'h2;
                end
            end
            if (i_col_clear) begin
                col_reg <= '0;
                ins_reg <= 2'h0;
            end
        end
    end

    a_rate_reset: assert property (@(posedge i_sys_clk)
        ($past(i_reset) && !i_reset) |-> div_reg == rate_div(PSP_R1200))
        else $error("rate after reset is not 1200");
    a_rate_load: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_rate_load |=> div_reg == rate_div($past(i_rate_sel)))
        else $error("rate command not applied");
    a_stop_mark: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (tx_st == PSP_TX_DATA && tx_bit_reg == 4'h7 && tx_cnt_reg == '0)
        |=> o_txd && tx_st == PSP_TX_STOP)
        else $error("stop bit missing after eight data bits");
    a_start_space: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        tx_load |=> !o_txd [*2])
        else $error("start bit not space");
    a_rx_msb: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_rx_valid |-> o_rx_data <= `PSP_RX_MASK)
        else $error("received byte above 127");
    a_no_xoff: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        tx_load |=> tx_sh_reg != `PSP_XOFF)
        else $error("xoff code transmitted as data");
    a_wrap_crlf: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (tx_load && tx_fifo && col_reg == 7'h4e && tx_byte >= `PSP_SPACE
         && !i_col_clear) |=> ins_reg == 2'h2)
        else $error("no wrap after column 79");
    a_col_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_col_clear |=> col_reg == '0 && ins_reg == 2'h0)
        else $error("column clear ignored");
    a_susp_now: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rx_xoff && i_output_active) |=> o_suspend && !tx_load)
        else $error("xoff during output did not suspend");
    a_susp_defer: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rx_xoff && !i_output_active) |=> !o_suspend && pend_reg)
        else $error("xoff outside output handled wrongly");
    a_resume: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        rx_xon |=> !o_suspend && !pend_reg)
        else $error("xon did not resume");
    a_upcase: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rx_done && !quote_reg && rx_byte >= `PSP_LOWER_A && rx_byte <= `PSP_LOWER_Z)
        |=> o_rx_valid && o_rx_data == ($past(rx_byte) & ~`PSP_CASE_BIT))
        else $error("lower case not folded");
endmodule : psp_program_port

// >>> core/psp_regs.svh
// Purpose: constants for the program serial port
// Assumes: 25 MHz system clock unless the top parameter says otherwise
// Notes:   codes are 7-bit ascii after receive masking
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// bit rates in bits per second
`define PSP_BAUD_300    32'd300
`define PSP_BAUD_600    32'd600
`define PSP_BAUD_1200   32'd1200
`define PSP_BAUD_2400   32'd2400
`define PSP_BAUD_4800   32'd4800
`define PSP_BAUD_9600   32'd9600
`define PSP_BAUD_19200  32'd19200

// rate code taken after reset (1200 baud)
`define PSP_RESET_RATE  3'h2

// frame and character constants
`define PSP_DATA_BITS   4'h8
`define PSP_RX_MASK     8'h7f
`define PSP_XOFF        8'h13
`define PSP_XON         8'h11
`define PSP_CR          8'h0d
`define PSP_LF          8'h0a
`define PSP_QUOTE       8'h22
`define PSP_SPACE       8'h20
`define PSP_LOWER_A     8'h61
`define PSP_LOWER_Z     8'h7a
`define PSP_CASE_BIT    8'h20
`define PSP_WRAP_COL    7'h4f

`endif

// >>> core/psp_stream_if.sv
// Purpose: valid/ready byte stream between port modules
// Assumes: one clock domain
// Notes:   src drives data and valid, snk drives ready
`timescale 1ns/100ps
interface psp_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input  ready);
    modport snk (input  data, input  valid, output ready);
endinterface : psp_stream_if

// >>> testbench/psp_term_model.sv
// Purpose: terminal model at the far end of the program port line
// Assumes: div is set by the bench to the clocks per bit in use
// Notes:   line idles at mark; no parity, one stop bit
`timescale 1ns/100ps
module psp_term_model (
    // clock
    input  wire logic i_sys_clk,
    // line from the port
    input  wire logic i_txd,
    // line into the port
    output logic      o_rxd
);
    int         div         = 240;
    int         n_frame_err = 0;
    logic [7:0] got_q[$];

    // idle mark before the first frame
    initial o_rxd = 1'b1;

    // one frame: space start, lsb first, mark stop
    task automatic send(input logic [7:0] b);
        @(negedge i_sys_clk);
        o_rxd = 1'b0; // start is space
        repeat (div) @(negedge i_sys_clk);
        for (int i = 0; i < 8; i++) begin // eight data bits
            o_rxd = b[i];
            repeat (div) @(negedge i_sys_clk);
        end
        o_rxd = 1'b1; // stop is mark
        repeat (div) @(negedge i_sys_clk);
    endtask : send

    // sample mid-bit; a low stop bit counts as a framing fault
    initial begin : rx_loop
        logic [7:0] b;
        forever begin
            @(negedge i_sys_clk);
            if (i_txd === 1'b0) begin
                repeat (div / 2) @(negedge i_sys_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (div) @(negedge i_sys_clk);
                    b[i] = i_txd; // lsb first
                end
                repeat (div) @(negedge i_sys_clk);
                if (i_txd !== 1'b1) n_frame_err++;
                got_q.push_back(b);
            end
        end
    end
endmodule : psp_term_model

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the program serial port
// Assumes: clk_hz lowered so every rate divides exactly
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
module testbench;
    import psp_pkg::*;
    localparam int CLK_HZ = 288000; // 240 clocks per bit at 1200 baud
    logic       i_sys_clk, i_reset, rxd, txd, rate_load, col_clear, out_act;
    logic       suspend, tx_valid, tx_ready, rx_valid;
    logic [2:0] rate_sel;
    logic [7:0] tx_data, rx_data;
    logic [7:0] rxq[$];
    int         n_mismatch = 0;
    int         tests_run  = 0;

    psp_program_port #(.CLK_HZ(CLK_HZ), .DEPTH(4)) dut_u (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_rxd(rxd), .o_txd(txd),
        .i_rate_sel(rate_sel), .i_rate_load(rate_load), .i_col_clear(col_clear),
        .i_output_active(out_act), .o_suspend(suspend), .i_tx_data(tx_data),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid));
    psp_term_model term_u (.i_sys_clk(i_sys_clk), .i_txd(txd), .o_rxd(rxd));

    // 25 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // collect delivered bytes at the sampling edge
    always @(posedge i_sys_clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);

    task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk8

    task automatic chk1(input logic exp, input logic got);
        chk8({7'h00, exp}, {7'h00, got});
    endtask : chk1

    // holds valid until ready is seen; caller lowers valid afterwards
    task automatic push(input logic [7:0] b);
        int n;
        n = 0;
        tx_data  = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 30000) begin
            @(negedge i_sys_clk);
            n++;
        end
        chk1(1'b1, tx_ready); // a stalled push counts as a mismatch
        @(negedge i_sys_clk);
    endtask : push

    // bounded wait for the next byte seen by the terminal
    task automatic chk_tx(input logic [7:0] exp);
        int n;
        n = 0;
        while (term_u.got_q.size() == 0 && n < 20000) begin
            @(negedge i_sys_clk);
            n++;
        end
        chk8(exp, term_u.got_q.size() ? term_u.got_q.pop_front() : 8'hxx);
    endtask : chk_tx

    task automatic t_reset;
        chk1(1'b1, txd);
        chk1(1'b0, suspend);
        chk1(1'b1, tx_ready);
        push(8'h41);
        tx_valid = 1'b0;
        chk_tx(8'h41); // default rate
        chk8(8'h00, term_u.n_frame_err[7:0]);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_rate;
        int bd[7];
        bd = '{300, 600, 1200, 2400, 4800, 9600, 19200};
        for (int c = 0; c < 7; c++) begin
            @(negedge i_sys_clk);
            rate_sel  = c[2:0];
            rate_load = 1'b1;
            @(negedge i_sys_clk);
            rate_load = 1'b0;
            term_u.div = CLK_HZ / bd[c];
            push(8'ha5);
            tx_valid = 1'b0;
            chk_tx(8'ha5);
        end
        $display("t_rate done");
    endtask : t_rate

    // full bytes, xoff code dropped, fifo filled to refusal
    task automatic t_tx_bytes;
        logic [7:0] in[6];
        logic [7:0] ex[5];
        logic       full;
        in   = '{8'hff, 8'h80, 8'h13, 8'h00, 8'h7e, 8'h3c};
        ex   = '{8'hff, 8'h80, 8'h00, 8'h7e, 8'h3c};
        full = 1'b0;
        foreach (in[i]) begin
            if (tx_ready === 1'b0) full = 1'b1;
            push(in[i]);
        end
        tx_valid = 1'b0;
        chk1(1'b1, full);
        foreach (ex[i]) chk_tx(ex[i]);
        $display("t_tx_bytes done");
    endtask : t_tx_bytes

    task automatic t_wrap;
        @(negedge i_sys_clk);
        col_clear = 1'b1;
        @(negedge i_sys_clk);
        col_clear = 1'b0;
        repeat (79) push(8'h41);
        push(8'h42);
        tx_valid = 1'b0;
        repeat (79) chk_tx(8'h41);
        chk_tx(8'h0d); // cr then lf after column 79
        chk_tx(8'h0a);
        chk_tx(8'h42);
        repeat (40) push(8'h41);
        tx_valid = 1'b0;
        repeat (40) chk_tx(8'h41);
        col_clear = 1'b1;
        @(negedge i_sys_clk);
        col_clear = 1'b0;
        repeat (40) push(8'h41);
        tx_valid = 1'b0;
        repeat (40) chk_tx(8'h41); // no wrap after clear
        repeat (300) @(negedge i_sys_clk);
        chk8(8'h00, term_u.got_q.size());
        $display("t_wrap done");
    endtask : t_wrap

    task automatic t_rx;
        logic [7:0] in[6];
        logic [7:0] ex[6];
        in = '{8'hc1, 8'h61, 8'h22, 8'h61, 8'h0d, 8'h62};
        ex = '{8'h41, 8'h41, 8'h22, 8'h61, 8'h0d, 8'h42};
        foreach (in[i]) begin
            term_u.send(in[i]);
            repeat (6) @(negedge i_sys_clk);
            chk8(ex[i], rxq.size() ? rxq.pop_front() : 8'hxx);
        end
        $display("t_rx done");
    endtask : t_rx

    task automatic t_flow;
        out_act = 1'b1;
        term_u.send(8'h13); // xoff while printing
        chk1(1'b1, suspend);
        chk8(8'h00, rxq.size()); // flow codes not delivered
        push(8'h55);
        tx_valid = 1'b0;
        repeat (600) @(negedge i_sys_clk);
        chk8(8'h00, term_u.got_q.size());
        term_u.send(8'h11);
        chk1(1'b0, suspend);
        chk_tx(8'h55);
        out_act = 1'b0;
        term_u.send(8'h13);
        chk1(1'b0, suspend);
        out_act = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk1(1'b1, suspend);
        term_u.send(8'h11);
        chk1(1'b0, suspend);
        out_act = 1'b0;
        $display("t_flow done");
    endtask : t_flow

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // watchdog, near twice the expected run yet under 100k cycles
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {rate_load, col_clear, out_act, tx_valid} = 4'h0;
        rate_sel = 3'h2;
        tx_data  = 8'h00;
        i_reset  = 1'b1;
        repeat (10) @(negedge i_sys_clk);
        i_reset = 1'b0;
        @(negedge i_sys_clk);
        t_reset();
        t_rate();
        t_tx_bytes();
        t_wrap();
        t_rx();
        t_flow();
        end_of_test();
    end
endmodule : testbench
